// ==== tma_card.sv ====
// Purpose: Inter-division communication card for one safeguard division
// Assumes: Link pins are asynchronous; controller side shares SYS_CLK
// Notes: Voting networks and plant port use separate pins
// Notes on behaviour
// - Pass status only after full authentication
// - Alarm on persistent authentication failures
// - Alarm when a division falls silent
// - Acknowledge, never depend on sender reply
// - Four nodes only; foreign traffic alarmed
// - Two redundant networks, independent receivers
// - Transfer only declared inputs and outputs
// - Double-buffered shared memory, no interrupts
// - Plant port reads controller side only
// - Time-stamp outbound data at origin
// - Received time never reaches shared memory
// - Alarm on disconnected fiber
// - Message loss keeps last state
// - Any two unbypassed trips initiate protection
// - Separate ports for voting and plant traffic
// - Separate networks per traffic class
`timescale 1ns/1ps
module tma_card
  import tma_pkg::*;
#(
  parameter int RX_TIMEOUT = RX_TIMEOUT_CYC
)
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [1:0] MY_ID,
  input wire logic [1:0] RX_SOF,
  input wire logic [15:0] RX_DATA,
  input wire logic [1:0] RX_TGL,
  input wire logic [1:0] RX_LOS,
  input wire logic CTRL_TRIP,
  input wire logic CTRL_BYP,
  input wire logic CTRL_SWAP,
  input wire logic ALM_CLR,
  input wire logic [31:0] NET_TIME,
  output logic [3:0] SHM_TRIP,
  output logic [3:0] SHM_BYP,
  output logic VOTE_TRIP,
  output logic [1:0] ACK_STB,
  output logic [15:0] ACK_SEQ,
  output logic [1:0] ALM_AUTH,
  output logic [1:0] ALM_FOREIGN,
  output logic [1:0] ALM_CABLE,
  output logic [3:0] ALM_SILENT,
  output logic PIN_VALID,
  output logic [7:0] PIN_DATA,
  output logic [31:0] PIN_TIME
);
  logic [1:0] id_reg;
  logic [SYNC_W-1:0] s1_reg [NUM_NET];
  logic [SYNC_W-1:0] s2_reg [NUM_NET];
  logic [1:0] tgl3_reg;
  logic [3:0] trip_reg;
  logic [3:0] byp_reg;
  logic [31:0] silent_cnt [NUM_DIV];
  logic [31:0] time_s1_reg;
  logic [31:0] time_s2_reg;
  logic [31:0] time_s3_reg;
  logic [31:0] time_reg;
  logic [8:0] pin_cnt;
  logic [3:0] eff_w;
  logic [2:0] votes_w;

  wire [1:0] acc_w;
  wire [1:0] foreign_w;
  wire [1:0] ack_w;
  wire [1:0] auth_w;
  wire [1:0] src_w [NUM_NET];
  wire [1:0] rtrip_w;
  wire [1:0] rbyp_w;
  wire [7:0] aseq_w [NUM_NET];
  wire [1:0] stb_w;
  wire [3:0] hit0_w;
  wire [3:0] hit1_w;
  wire [3:0] upd_w;
  wire [3:0] new_trip_w;
  wire [3:0] new_byp_w;
  wire own_trip_w = CTRL_TRIP && DECL_OUT_TRIP;
  wire own_byp_w = CTRL_BYP && DECL_OUT_BYP;
  wire pin_tick_w = pin_cnt == 9'(PIN_PERIOD_CYC - 1);

  function automatic logic div_hit(input logic a, input logic [1:0] s, input int d);
    return a && (s == 2'(d));
  endfunction

  tma_net_if nif [NUM_NET] ();

  // voting pins apart from plant pins
  // each network on its own pins
  for (genvar n = 0; n < NUM_NET; n++) begin : g_net
    assign stb_w[n] = s2_reg[n][SY_TGL] ^ tgl3_reg[n];
    assign acc_w[n] = nif[n].acc;
    assign foreign_w[n] = nif[n].foreign;
    assign ack_w[n] = nif[n].ack;
    assign auth_w[n] = nif[n].alm_auth;
    assign src_w[n] = nif[n].src;
    assign rtrip_w[n] = nif[n].trip;
    assign rbyp_w[n] = nif[n].byp;
    assign aseq_w[n] = nif[n].ack_seq;
    tma_rx_check u_chk (
      .clk(SYS_CLK),
      .rst(RST),
      .my_id(id_reg),
      .sof(s2_reg[n][SY_SOF]),
      .data(s2_reg[n][7:0]),
      .stb(stb_w[n]),
      .net(nif[n])
    );
  end

  // Network A wins if both deliver the same division at once
  for (genvar d = 0; d < NUM_DIV; d++) begin : g_div
    assign hit0_w[d] = div_hit(acc_w[0], src_w[0], d);
    assign hit1_w[d] = div_hit(acc_w[1], src_w[1], d);
    assign upd_w[d] = hit0_w[d] || hit1_w[d];
    assign new_trip_w[d] = hit0_w[d] ? rtrip_w[0] : rtrip_w[1];
    assign new_byp_w[d] = hit0_w[d] ? rbyp_w[0] : rbyp_w[1];
  end

  always_comb begin
    votes_w = 3'h0;
    for (int d = 0; d < NUM_DIV; d++) begin
      eff_w[d] = (id_reg == 2'(d)) ? (own_trip_w && !own_byp_w) : (trip_reg[d] && !byp_reg[d]);
      votes_w = votes_w + {2'h0, eff_w[d]};
    end
  end

  // Strap is static, caught while reset is held
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      id_reg <= MY_ID;
    end
  end

  // Link bytes must stay stable around their toggle edge
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      tgl3_reg <= 2'h0;
      for (int n = 0; n < NUM_NET; n++) begin
        s1_reg[n] <= '0;
        s2_reg[n] <= '0;
      end
    end else begin
      for (int n = 0; n < NUM_NET; n++) begin
        s1_reg[n] <= {RX_LOS[n], RX_TGL[n], RX_SOF[n], RX_DATA[8*n +: 8]};
        s2_reg[n] <= s1_reg[n];
        tgl3_reg[n] <= s2_reg[n][SY_TGL];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ACK_STB <= 2'h0;
      ACK_SEQ <= 16'h0000;
      ALM_AUTH <= 2'h0;
      ALM_FOREIGN <= 2'h0;
      ALM_CABLE <= 2'h0;
    end else begin
      for (int n = 0; n < NUM_NET; n++) begin
        ACK_STB[n] <= ack_w[n];
        if (ack_w[n]) begin
          ACK_SEQ[8*n +: 8] <= aseq_w[n];
        end
        ALM_AUTH[n] <= auth_w[n];
        // sticky, a new event beats clear
        ALM_FOREIGN[n] <= foreign_w[n] || (ALM_FOREIGN[n] && !ALM_CLR);
        ALM_CABLE[n] <= s2_reg[n][SY_LOS];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      trip_reg <= 4'h0;
      byp_reg <= 4'h0;
      ALM_SILENT <= 4'h0;
      for (int d = 0; d < NUM_DIV; d++) begin
        silent_cnt[d] <= 32'h0;
      end
    end else begin
      for (int d = 0; d < NUM_DIV; d++) begin
        if (upd_w[d]) begin
          trip_reg[d] <= new_trip_w[d];
          byp_reg[d] <= new_byp_w[d];
          silent_cnt[d] <= 32'h0;
        end else if (silent_cnt[d] != 32'(RX_TIMEOUT)) begin
          silent_cnt[d] <= silent_cnt[d] + 32'h1;
        end
        ALM_SILENT[d] <= (id_reg != 2'(d)) && (silent_cnt[d] == 32'(RX_TIMEOUT));
      end
    end
  end

  // front bank moves only on swap
  // no time path into this bank
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      SHM_TRIP <= 4'h0;
      SHM_BYP <= 4'h0;
      VOTE_TRIP <= 1'b0;
    end else begin
      if (CTRL_SWAP) begin
        SHM_TRIP <= trip_reg & DECL_IN_TRIP;
        SHM_BYP <= byp_reg & DECL_IN_BYP;
      end
      VOTE_TRIP <= votes_w >= 3'h2;
    end
  end

  // Time word taken only when two synced samples agree, so a word caught mid-change is never stamped
  // plant port only reads controller side
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      time_s1_reg <= 32'h0;
      time_s2_reg <= 32'h0;
      time_s3_reg <= 32'h0;
      time_reg <= 32'h0;
      pin_cnt <= 9'h000;
      PIN_VALID <= 1'b0;
      PIN_DATA <= 8'h00;
      PIN_TIME <= 32'h0;
    end else begin
      time_s1_reg <= NET_TIME;
      time_s2_reg <= time_s1_reg;
      time_s3_reg <= time_s2_reg;
      if (time_s3_reg == time_s2_reg) begin
        time_reg <= time_s3_reg;
      end
      pin_cnt <= pin_tick_w ? 9'h000 : pin_cnt + 9'h001;
      PIN_VALID <= pin_tick_w;
      if (pin_tick_w) begin
        PIN_DATA <= {VOTE_TRIP, own_trip_w, own_byp_w, 1'b0, SHM_TRIP};
        PIN_TIME <= time_reg;
      end
    end
  end

  vote_two_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (votes_w >= 3'h2) |=> VOTE_TRIP)
    else $error("two trips did not initiate vote");
  vote_one_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (votes_w < 3'h2) |=> !VOTE_TRIP)
    else $error("vote raised with fewer than two trips");
  foreign_flag_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    foreign_w[0] |-> !acc_w[0] ##1 ALM_FOREIGN[0])
    else $error("foreign frame not ignored and alarmed");
  sequence los_on_s;
    RX_LOS[0] [*3];
  endsequence
  sequence los_off_s;
    !RX_LOS[0] [*3];
  endsequence
  cable_alarm_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    los_on_s |=> ALM_CABLE[0])
    else $error("fiber loss not alarmed");
  cable_clear_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    los_off_s |=> !ALM_CABLE[0])
    else $error("fiber alarm without loss");
  silent_alarm_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (silent_cnt[1] == 32'(RX_TIMEOUT)) && (id_reg != 2'h1) |=> ALM_SILENT[1])
    else $error("silent division not alarmed");
  hold_state_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    !upd_w[2] |=> $stable(trip_reg[2]) && $stable(byp_reg[2]))
    else $error("status changed without accepted message");
  swap_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    !CTRL_SWAP |=> $stable(SHM_TRIP) && $stable(SHM_BYP))
    else $error("shared memory changed outside swap");
  swap_load_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    CTRL_SWAP |=> SHM_TRIP == ($past(trip_reg) & DECL_IN_TRIP))
    else $error("shared memory load ignores declarations");
  stamp_time_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    pin_tick_w |=> PIN_VALID && PIN_TIME == $past(time_reg))
    else $error("outbound data not stamped at origin");
  plant_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    !pin_tick_w |=> !PIN_VALID && $stable(PIN_DATA))
    else $error("plant port changed outside its slot");
  silent_own_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    !ALM_SILENT[id_reg])
    else $error("own division flagged silent");
  silent_clear_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    upd_w[1] |=> ##1 !ALM_SILENT[1])
    else $error("silence alarm kept after accepted frame");
  foreign_clear_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    ALM_CLR && !foreign_w[0] |=> !ALM_FOREIGN[0])
    else $error("foreign alarm not cleared");
  foreign_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    ALM_FOREIGN[0] && !ALM_CLR |=> ALM_FOREIGN[0])
    else $error("foreign alarm dropped without clear");
  ack_pulse_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    ACK_STB[0] |=> !ACK_STB[0])
    else $error("acknowledge strobe longer than one cycle");
endmodule

// ==== tma_pkg.sv ====
// Purpose: Shared constants for the trip message authenticator
// Assumes: 50 MHz system clock, six-byte inter-division frames
// Notes: Frame is src, dst, seq, status, hash, crc
package tma_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int NUM_DIV = 4;
  localparam int NUM_NET = 2;
  localparam int FRAME_LEN = 6;
  localparam int B_SRC = 0;
  localparam int B_DST = 1;
  localparam int B_SEQ = 2;
  localparam int B_STAT = 3;
  localparam int B_HASH = 4;
  localparam int B_CRC = 5;
  localparam int STAT_TRIP = 0;
  localparam int STAT_BYP = 1;
  localparam int SYNC_W = 11;
  localparam int SY_SOF = 8;
  localparam int SY_TGL = 9;
  localparam int SY_LOS = 10;
  // Arbitrary shared key, not tied to any product
  localparam logic [7:0] HASH_KEY = 8'h5a;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [2:0] FAIL_RUN = 3'h4;
  localparam int RX_TIMEOUT_MS = 100;
  localparam int RX_TIMEOUT_CYC = RX_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int PIN_PERIOD_US = 10;
  localparam int PIN_PERIOD_CYC = PIN_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam logic [3:0] DECL_IN_TRIP = 4'hf;
  localparam logic [3:0] DECL_IN_BYP = 4'hf;
  localparam logic DECL_OUT_TRIP = 1'b1;
  localparam logic DECL_OUT_BYP = 1'b1;

  function automatic logic [7:0] tma_crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage

// ==== tma_net_if.sv ====
// Purpose: Verdict of one network receiver toward the card core
// Assumes: Single clock domain
// Notes: All strobes are one-cycle pulses
`timescale 1ns/1ps
interface tma_net_if;
  logic acc;
  logic fail;
  logic foreign;
  logic ack;
  logic [1:0] src;
  logic trip;
  logic byp;
  logic [7:0] ack_seq;
  logic alm_auth;
  modport chk (output acc, fail, foreign, ack, src, trip, byp, ack_seq, alm_auth);
  modport card (input acc, fail, foreign, ack, src, trip, byp, ack_seq, alm_auth);
endinterface

// ==== tma_rx_check.sv ====
// Purpose: Frame assembly and authentication for one voting network
// Assumes: Byte strobes at least four clocks apart
// Notes: Verdict is given two clocks after the last byte strobe
`timescale 1ns/1ps
module tma_rx_check
  import tma_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] my_id,
  input wire logic sof,
  input wire logic [7:0] data,
  input wire logic stb,
  tma_net_if.chk net
);
  logic [7:0] frm_reg [FRAME_LEN];
  logic [2:0] cnt_reg;
  logic done_reg;
  logic [7:0] seq_reg [NUM_DIV];
  logic [3:0] seen_reg;
  logic [2:0] run_reg;
  logic [7:0] crc_w;

  wire [1:0] src_w = frm_reg[B_SRC][1:0];
  wire foreign_w = (frm_reg[B_SRC][7:2] != 6'h00) || (src_w == my_id);
  wire dst_ok_w = frm_reg[B_DST] == {6'h00, my_id};
  wire seq_ok_w = !seen_reg[src_w] || (frm_reg[B_SEQ] == seq_reg[src_w] + 8'h01);
  wire hash_ok_w = frm_reg[B_HASH] == (frm_reg[0] ^ frm_reg[1] ^ frm_reg[2] ^ frm_reg[3] ^ HASH_KEY);
  wire crc_ok_w = frm_reg[B_CRC] == crc_w;
  wire good_w = !foreign_w && dst_ok_w && seq_ok_w && hash_ok_w && crc_ok_w;

  always_comb begin
    crc_w = CRC_INIT;
    for (int i = 0; i < B_CRC; i++) begin
      crc_w = tma_crc8(crc_w, frm_reg[i]);
    end
  end

  always_ff @(posedge clk) begin
    if (stb) begin
      if (sof) begin
        frm_reg[0] <= data;
      end else if (cnt_reg != 3'h0) begin
        frm_reg[cnt_reg] <= data;
      end
    end
  end

  // A stray byte without start is dropped, no partial frame escapes
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 3'h0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= stb && !sof && cnt_reg == 3'(FRAME_LEN - 1);
      if (stb && sof) begin
        cnt_reg <= 3'h1;
      end else if (stb && cnt_reg != 3'h0) begin
        cnt_reg <= (cnt_reg == 3'(FRAME_LEN - 1)) ? 3'h0 : cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      net.acc <= 1'b0;
      net.fail <= 1'b0;
      net.foreign <= 1'b0;
      net.ack <= 1'b0;
      net.src <= 2'h0;
      net.trip <= 1'b0;
      net.byp <= 1'b0;
      net.ack_seq <= 8'h00;
      net.alm_auth <= 1'b0;
      seen_reg <= 4'h0;
      run_reg <= 3'h0;
      for (int d = 0; d < NUM_DIV; d++) begin
        seq_reg[d] <= 8'h00;
      end
    end else begin
      net.acc <= done_reg && good_w;
      net.fail <= done_reg && !good_w;
      net.foreign <= done_reg && foreign_w;
      net.ack <= done_reg && dst_ok_w;
      if (done_reg) begin
        net.src <= src_w;
        net.trip <= frm_reg[B_STAT][STAT_TRIP];
        net.byp <= frm_reg[B_STAT][STAT_BYP];
        net.ack_seq <= frm_reg[B_SEQ];
      end
      if (done_reg && good_w) begin
        seq_reg[src_w] <= frm_reg[B_SEQ];
        seen_reg[src_w] <= 1'b1;
        run_reg <= 3'h0;
        net.alm_auth <= 1'b0;
      end else if (done_reg) begin
        if (run_reg < FAIL_RUN) begin
          run_reg <= run_reg + 3'h1;
        end
        net.alm_auth <= run_reg >= FAIL_RUN - 3'h1;
      end
    end
  end

  sequence bad_frame_s;
    done_reg && !good_w;
  endsequence
  sequence good_frame_s;
    done_reg && good_w;
  endsequence

  accept_gate_a: assert property (@(posedge clk) disable iff (rst)
    bad_frame_s |=> !net.acc && net.fail)
    else $error("rejected frame reached controller path");
  good_pass_a: assert property (@(posedge clk) disable iff (rst)
    good_frame_s |=> net.acc ##1 !net.acc)
    else $error("valid frame not passed");
  auth_run_a: assert property (@(posedge clk) disable iff (rst)
    bad_frame_s and (run_reg == 3'h0) |=> !net.alm_auth)
    else $error("alarm raised on a single rejected frame");
  ack_indep_a: assert property (@(posedge clk) disable iff (rst)
    done_reg && dst_ok_w |=> net.ack)
    else $error("addressed frame not acknowledged");
endmodule

// ==== tma_peer.sv ====
// Purpose: Sender on one voting network, standing in for another division
// Assumes: Destination is division 0, the bench's own id
// Notes: A released data line shows the inverted byte, not the last one
`timescale 1ns/1ps
module tma_peer
  import tma_pkg::*;
(
  input wire logic clk,
  output logic sof,
  output logic [7:0] data,
  output logic tgl
);
  initial begin
    sof = 1'b0;
    data = 8'h00;
    tgl = 1'b0;
  end

  task automatic send(input logic [7:0] src, input logic [7:0] seq, input logic [7:0] stat,
                      input logic bad_hash, input logic bad_crc);
    logic [7:0] f [6];
    logic [7:0] c;
    f[0] = src;
    f[1] = 8'h00;
    f[2] = seq;
    // status carries only trip and bypass
    f[3] = stat & 8'h03;
    f[4] = f[0] ^ f[1] ^ f[2] ^ f[3] ^ HASH_KEY ^ {7'h00, bad_hash};
    c = 8'h00;
    for (int i = 0; i < 5; i++) begin
      c = c ^ f[i];
      for (int j = 0; j < 8; j++) begin
        c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
    end
    f[5] = c ^ {7'h00, bad_crc};
    // Held three clocks either side of each toggle
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      sof <= (i == 0);
      data <= f[i];
      repeat (3) @(posedge clk);
      tgl <= ~tgl;
      repeat (3) @(posedge clk);
      sof <= 1'b0;
      data <= ~f[i];
    end
  endtask
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the card, model kept in integers
// Assumes: Own id 0, silence timeout shortened to 50 cycles
// Notes: Outputs sampled on the falling edge, inputs driven on the rising
`timescale 1ns/1ps
module tb_top
  import tma_pkg::*;
;
  localparam int TMO = 50;
  logic sys_clk, rst, ctrl_trip, ctrl_byp, ctrl_swap, alm_clr;
  logic [1:0] rx_los, ack_stb, alm_auth, alm_foreign, alm_cable;
  wire [1:0] rx_sof, rx_tgl;
  wire [15:0] rx_data;
  logic [15:0] ack_seq;
  logic [31:0] net_time, pin_time;
  logic [3:0] shm_trip, shm_byp, alm_silent;
  logic vote_trip, pin_valid;
  logic [7:0] pin_data;
  int num_errors, n_compared, cyc;
  int m_trip[4], m_byp[4], m_seq[4], m_fail[2];
  bit m_seen[4];

  always #10 sys_clk = ~sys_clk;

  tma_peer i_peer0 (.clk(sys_clk), .sof(rx_sof[0]), .data(rx_data[7:0]), .tgl(rx_tgl[0]));
  tma_peer i_peer1 (.clk(sys_clk), .sof(rx_sof[1]), .data(rx_data[15:8]), .tgl(rx_tgl[1]));

  tma_card #(.RX_TIMEOUT(TMO)) i_dut (
    .SYS_CLK(sys_clk), .RST(rst), .MY_ID(2'h0), .RX_SOF(rx_sof), .RX_DATA(rx_data), .RX_TGL(rx_tgl),
    .RX_LOS(rx_los), .CTRL_TRIP(ctrl_trip), .CTRL_BYP(ctrl_byp), .CTRL_SWAP(ctrl_swap), .ALM_CLR(alm_clr),
    .NET_TIME(net_time), .SHM_TRIP(shm_trip), .SHM_BYP(shm_byp), .VOTE_TRIP(vote_trip), .ACK_STB(ack_stb),
    .ACK_SEQ(ack_seq), .ALM_AUTH(alm_auth), .ALM_FOREIGN(alm_foreign), .ALM_CABLE(alm_cable),
    .ALM_SILENT(alm_silent), .PIN_VALID(pin_valid), .PIN_DATA(pin_data), .PIN_TIME(pin_time)
  );

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hang costs one mismatch and ends the run with a report
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic frame(input int net, input int src, input int seq, input int stat, input bit bh, input bit bc);
    int k;
    bit ok;
    if (net == 0) begin
      i_peer0.send(8'(src), 8'(seq), 8'(stat), bh, bc);
    end else begin
      i_peer1.send(8'(src), 8'(seq), 8'(stat), bh, bc);
    end
    k = 0;
    @(negedge sys_clk);
    while (ack_stb[net] !== 1'b1 && k < 20) begin
      @(negedge sys_clk);
      k++;
    end
    check_val("ack_stb", 32'h1, 32'(ack_stb[net]));
    check_val("ack_seq", 32'(seq % 256), 32'(ack_seq[net*8 +: 8]));
    ok = src >= 1 && src <= 3 && !bh && !bc && (!m_seen[src] || seq % 256 == (m_seq[src] + 1) % 256);
    if (ok) begin
      m_seen[src] = 1'b1;
      m_seq[src] = seq % 256;
      m_trip[src] = stat % 2;
      m_byp[src] = stat / 2;
      m_fail[net] = 0;
    end else begin
      m_fail[net]++;
    end
    if (src != 0) begin
      check_val("alm_auth", 32'(m_fail[net] >= 4), 32'(alm_auth[net]));
    end
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic swap_chk();
    logic [3:0] et, eb;
    int votes;
    @(posedge sys_clk);
    ctrl_swap <= 1'b1;
    @(posedge sys_clk);
    ctrl_swap <= 1'b0;
    @(negedge sys_clk);
    // Model read after the edges so a control input driven just before is seen
    et = 4'h0;
    eb = 4'h0;
    votes = int'(ctrl_trip && !ctrl_byp);
    for (int i = 1; i < 4; i++) begin
      et[i] = m_trip[i][0];
      eb[i] = m_byp[i][0];
      votes += int'(m_trip[i] == 1 && m_byp[i] == 0);
    end
    check_val("shm_trip", 32'(et[3:1]), 32'(shm_trip[3:1]));
    check_val("shm_byp", 32'(eb[3:1]), 32'(shm_byp[3:1]));
    check_val("vote_trip", 32'(votes >= 2), 32'(vote_trip));
  endtask

  initial begin
    int s1, s2, s3, k, vt;
    logic [7:0] epd;
    sys_clk = 1'b0;
    rst = 1'b1;
    ctrl_trip = 1'b0;
    ctrl_byp = 1'b0;
    ctrl_swap = 1'b0;
    alm_clr = 1'b0;
    rx_los = 2'h0;
    net_time = 32'h0;
    void'($urandom(32'h63444e48));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    check_val("idle outputs", 32'h0, 32'({shm_trip, vote_trip, ack_stb, alm_auth, alm_foreign, pin_valid}));
    $display("test reset done");
    s1 = int'($urandom % 200);
    s2 = int'($urandom % 200);
    s3 = int'($urandom % 256);
    frame(0, 1, s1, 1, 1'b0, 1'b0);
    swap_chk();
    frame(1, 2, s2, 1, 1'b0, 1'b0);
    swap_chk();
    frame(1, 2, s2 + 1, 3, 1'b0, 1'b0);
    swap_chk();
    @(posedge sys_clk);
    ctrl_trip <= 1'b1;
    swap_chk();
    $display("test vote done");
    frame(0, 1, s1 + 5, 0, 1'b0, 1'b0);
    frame(0, 1, s1 + 1, 0, 1'b0, 1'b1);
    frame(0, 1, s1 + 1, 0, 1'b1, 1'b0);
    swap_chk();
    frame(0, 1, s1 + 1, 0, 1'b1, 1'b0);
    frame(0, 3, s3, 0, 1'b0, 1'b0);
    $display("test auth done");
    frame(0, 0, 7, 1, 1'b0, 1'b0);
    check_val("alm_foreign", 32'h1, 32'(alm_foreign));
    @(posedge sys_clk);
    alm_clr <= 1'b1;
    @(posedge sys_clk);
    alm_clr <= 1'b0;
    @(negedge sys_clk);
    check_val("alm_foreign", 32'h0, 32'(alm_foreign));
    swap_chk();
    $display("test foreign done");
    @(posedge sys_clk);
    rx_los <= 2'h3;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    check_val("alm_cable", 32'h3, 32'(alm_cable));
    @(posedge sys_clk);
    rx_los <= 2'h0;
    repeat (TMO + 20) @(posedge sys_clk);
    @(negedge sys_clk);
    check_val("alm_cable", 32'h0, 32'(alm_cable));
    check_val("alm_silent", 32'he, 32'(alm_silent));
    swap_chk();
    $display("test alarms done");
    @(posedge sys_clk);
    net_time <= $urandom;
    ctrl_byp <= 1'b1;
    repeat (10) @(posedge sys_clk);
    k = 0;
    @(negedge sys_clk);
    while (pin_valid !== 1'b1 && k < 600) begin
      @(negedge sys_clk);
      k++;
    end
    check_val("pin_valid", 32'h1, 32'(pin_valid));
    check_val("pin_time", net_time, pin_time);
    vt = int'(ctrl_trip && !ctrl_byp);
    for (int i = 1; i < 4; i++) begin
      vt += int'(m_trip[i] == 1 && m_byp[i] == 0);
    end
    epd = {(vt >= 2), ctrl_trip, ctrl_byp, 1'b0, m_trip[3][0], m_trip[2][0], m_trip[1][0], 1'b0};
    check_val("pin_data", 32'(epd), 32'(pin_data));
    swap_chk();
    $display("test plant port done");
    report_and_stop();
  end
endmodule
